// ==== pkg/gpag_pkg.sv ====
// Constants and carrier types of the eight-pin port with analog share.
// Assumes an APB master with 16-bit byte addresses and 32-bit data.
//
// What this block does
// - Eight data latch bits, untouched by reset
// - Direction bit one drives pin, zero floats
// - Reset clears all direction bits to input
// - Data read: latch if output, pin if input
// - Data write with pstrb[0] set loads latch, whatever the direction
// - Analog channel claim overrides direction and output
// - Unclaimed pins keep normal digital behaviour
// - Direction register reads back last write
`default_nettype none

package gpag_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam int unsigned     GPAG_W          = 8;
  localparam int unsigned     GPAG_AW         = 16;
  // Word indices; byte address is four times the index
  localparam logic [15:0]     GPAG_DATA_IDX   = 16'h0441;
  localparam logic [15:0]     GPAG_DIR_IDX    = 16'h0445;
  localparam logic [15:0]     GPAG_DATA_ADDR  = 16'h1104;
  localparam logic [15:0]     GPAG_DIR_ADDR   = 16'h1114;
  localparam logic [7:0]      GPAG_DIR_RST    = 8'h00;
  localparam logic [31:0]     GPAG_RD_ZERO    = 32'h00000000;

  // ---------------------------------------------------------------
  // Carriers
  // ---------------------------------------------------------------
  // Pad drive toward the pin ring
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] ana;
  } gpag_pad_t;

endpackage : gpag_pkg

`default_nettype wire

// ==== src/gpag_port.sv ====
// Eight-pin parallel port whose pins may be claimed as analog inputs.
// Assumes synchronous pins, a single clock pclk and an APB master.
//
// The APB slave port was decided locally.
`default_nettype none

module gpag_port
(
  input  wire logic                  pclk,     // Bus clock
  input  wire logic                  presetn,  // Async reset, low
  input  wire logic                  ce,       // Clock enable
  input  wire logic                  psel,     // APB select
  input  wire logic                  penable,  // APB access phase
  input  wire logic                  pwrite,   // APB direction
  input  wire logic [15:0]           paddr,    // APB byte address
  input  wire logic [31:0]           pwdata,   // APB write data
  input  wire logic [3:0]            pstrb,    // APB byte strobes
  output logic                       pready,   // APB ready
  output logic                       pslverr,  // APB error
  output logic [31:0]                prdata,   // APB read data
  input  wire logic [7:0]            pin_in,   // Pin levels
  input  wire logic [7:0]            ana_claim,// Converter channel claim
  output gpag_pkg::gpag_pad_t        pad       // Pad controls
);
  import gpag_pkg::*;

  // ---------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------
  logic        setup;
  logic        access;
  logic        hit_data;
  logic        hit_dir;
  logic        wr_data;
  logic        wr_dir;
  logic        rd_cap;
  logic        rd_ok_q;
  logic        rd_ok_d;

  // Setup cycle prepares read data; access completes with ce
  always_comb
  begin
    setup    = psel & ~penable;
    access   = psel & penable;
    hit_data = (paddr == GPAG_DATA_ADDR);
    hit_dir  = (paddr == GPAG_DIR_ADDR);
    wr_data  = access & pwrite & ce & pstrb[0] & hit_data;
    wr_dir   = access & pwrite & ce & pstrb[0] & hit_dir;
    rd_cap   = ce & psel & ~pwrite & ~rd_ok_q;
  end

  // Writes finish at once; reads wait until their data is captured
  always_comb
  begin
    pready  = ce & (pwrite | rd_ok_q);
    pslverr = access & ~(hit_data | hit_dir);
  end

  // ---------------------------------------------------------------
  // Read handshake
  // ---------------------------------------------------------------
  // Set when prdata holds this transfer's data; a setup cycle lost to a
  // low ce defers capture into access, costing one wait state there
  always_comb
  begin
    rd_ok_d = rd_ok_q;
    if (access & pready)
    begin
      rd_ok_d = 1'b0;
    end
    else if (rd_cap)
    begin
      rd_ok_d = 1'b1;
    end
  end

  // Cleared by reset so the first read always captures
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rd_ok_q <= 1'b0;
    end
    else
    begin
      rd_ok_q <= rd_ok_d;
    end
  end

  // ---------------------------------------------------------------
  // Data latch
  // ---------------------------------------------------------------
  logic [7:0] latch_q;
  logic [7:0] latch_d;

  // Write lands whatever the direction holds
  always_comb
  begin
    latch_d = latch_q;
    if (wr_data)
    begin
      latch_d = pwdata[7:0];
    end
  end

  // No reset: contents survive a system reset
  always_ff @(posedge pclk)
  begin
    latch_q <= latch_d;
  end

  // ---------------------------------------------------------------
  // Direction register
  // ---------------------------------------------------------------
  logic [7:0] dir_q;
  logic [7:0] dir_d;

  always_comb
  begin
    dir_d = dir_q;
    if (wr_dir)
    begin
      dir_d = pwdata[7:0];
    end
  end

  // Reset makes every pin an input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      dir_q <= GPAG_DIR_RST;
    end
    else
    begin
      dir_q <= dir_d;
    end
  end

  // ---------------------------------------------------------------
  // Pin drive
  // ---------------------------------------------------------------
  logic [7:0] oe_bit;
  logic [7:0] rd_mux;

  // Per pin: analog claim beats direction; read picks latch or pin
  for (genvar i = 0; i < 8; i++)
  begin : g_pin
    always_comb
    begin
      oe_bit[i] = dir_q[i] & ~ana_claim[i];
      rd_mux[i] = dir_q[i] ? latch_q[i] : pin_in[i];
    end
  end

  // Output level straight from the latch flop, enable gated
  always_comb
  begin
    pad.out = latch_q;
    pad.oe  = oe_bit;
    pad.ana = ana_claim;
  end

  // ---------------------------------------------------------------
  // Read data
  // ---------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  // Captured once per read, normally in setup; pin sampled there
  always_comb
  begin
    rdata_d = rdata_q;
    if (rd_cap)
    begin
      if (hit_data)
      begin
        rdata_d = {24'h000000, rd_mux};
      end
      else if (hit_dir)
      begin
        rdata_d = {24'h000000, dir_q};
      end
      else
      begin
        rdata_d = GPAG_RD_ZERO;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rdata_q <= GPAG_RD_ZERO;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  always_comb
  begin
    prdata = rdata_q;
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence s_rd_setup(logic hit);
    ce && psel && !penable && !pwrite && hit;
  endsequence

  sequence s_wr_done(logic hit);
    ce && psel && penable && pwrite && pstrb[0] && hit;
  endsequence

  // Read whose setup fell in a frozen cycle, captured in access
  sequence s_rd_late(logic hit);
    ce && psel && penable && !pwrite && !rd_ok_q && hit;
  endsequence

  // Latch takes the written byte regardless of direction
  a_latch_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_done(hit_data) |=> latch_q == $past(pwdata[7:0]))
    else $error("latch missed a write");

  // Latch holds while nothing writes it
  a_latch_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    !wr_data |=> $stable(latch_q))
    else $error("latch changed without a write");

  // Direction holds its written value
  a_dir_write: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_done(hit_dir) |=> dir_q == $past(pwdata[7:0]))
    else $error("direction missed a write");

  // Direction readback appears in the access phase
  a_dir_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_rd_setup(hit_dir) |=> prdata[7:0] == $past(dir_q))
    else $error("direction readback wrong");

  // Data read mixes latch and sampled pin per direction
  a_data_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_rd_setup(hit_data) |=>
      prdata[7:0] == (($past(dir_q) & $past(latch_q)) |
                      (~$past(dir_q) & $past(pin_in))))
    else $error("data read mixes wrongly");

  // Reset leaves every pin undriven
  a_reset_input: assert property (
    @(posedge pclk)
    $rose(presetn) |-> dir_q == 8'h00 && pad.oe == 8'h00)
    else $error("direction not cleared by reset");

  // Claimed pin is never driven
  a_analog_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pad.oe & ana_claim) == 8'h00)
    else $error("driver on analog pin");

  // Unclaimed output pin drives, input pin floats
  a_digital_keep: assert property (
    @(posedge pclk) disable iff (!presetn)
    (pad.oe & ~ana_claim) == (dir_q & ~ana_claim))
    else $error("digital enable wrong");

  // Driven level follows a latch write the next cycle
  a_drive_latch: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_wr_done(hit_data) ##0 (dir_q[0] && !ana_claim[0]) ##1 !ana_claim[0]
      |-> pad.out[0] == $past(pwdata[0]) && pad.oe[0])
    else $error("pin not driven from latch");

  // Bus stalls while the clock enable is low
  a_ce_freeze: assert property (
    @(posedge pclk) disable iff (!presetn)
    !ce |=> $stable(dir_q) && $stable(prdata) && $stable(latch_q) && $stable(rd_ok_q))
    else $error("state moved while frozen");

  // Unmapped access errors, mapped access does not
  a_decode_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable |-> pslverr == !(hit_data || hit_dir))
    else $error("decode error wrong");

  // A read never completes before its data is captured
  a_read_wait: assert property (
    @(posedge pclk) disable iff (!presetn)
    psel && penable && !pwrite && !rd_ok_q |-> !pready)
    else $error("read completed without data");

  // Every setup cycle starts with no data pending
  a_setup_fresh: assert property (
    @(posedge pclk) disable iff (!presetn)
    setup |-> !rd_ok_q)
    else $error("stale read data pending");

  // Late capture mixes latch and pin the same way
  a_late_read: assert property (
    @(posedge pclk) disable iff (!presetn)
    s_rd_late(hit_data) |=>
      prdata[7:0] == (($past(dir_q) & $past(latch_q)) |
                      (~$past(dir_q) & $past(pin_in))))
    else $error("late data read wrong");

endmodule : gpag_port

`default_nettype wire

// ==== tb/gpag_pin_model.sv ====
// Pin ring model: pin levels seen by the port.
// Assumes pad controls from gpag_port and an outside level from the bench.
`default_nettype none

module gpag_pin_model
  import gpag_pkg::*;
(
  input  wire gpag_pkg::gpag_pad_t pad,     // Pad controls
  input  wire logic [7:0]          ext_lvl, // Outside level
  output logic [7:0]               pin_in   // Pin levels
);
  // ---------------------------------------------------------------
  // Wire
  // ---------------------------------------------------------------
  // Driven pins show the latch; floating pins show the outside
  assign pin_in = (pad.oe & pad.out) | (~pad.oe & ext_lvl);
endmodule : gpag_pin_model

`default_nettype wire

// ==== tb/tb_gpag_port.sv ====
// Random bench of the eight-pin port with analog share.
// Assumes the pin model and the package; ce stalls at random later on.
`default_nettype none

module tb_gpag_port;
  timeunit 1ns;
  timeprecision 1ps;
  import gpag_pkg::*;
  logic             pclk = 1'b0;
  logic             presetn = 1'b0;
  logic             ce = 1'b1;
  logic             psel = 1'b0;
  logic             penable = 1'b0;
  logic             pwrite = 1'b0;
  logic [15:0]      paddr = '0;
  logic [31:0]      pwdata = '0;
  logic [3:0]       pstrb = '0;
  logic [7:0]       ana_claim = '0;
  logic [7:0]       ext_lvl = '0;
  logic             pready, pslverr, err;
  logic [31:0]      prdata, rd;
  logic [7:0]       pin_in, lat, dir, ext, clm;
  gpag_pad_t        pad;
  int               fails = 0;
  int               check_count = 0;
  int               cycles = 0;
  bit               ce_jit = 1'b0;

  gpag_port uut (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(pstrb), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .pin_in(pin_in), .ana_claim(ana_claim), .pad(pad));
  gpag_pin_model u_pins (.pad(pad), .ext_lvl(ext_lvl), .pin_in(pin_in));

  // ---------------------------------------------------------------
  // Clock and hang guard
  // ---------------------------------------------------------------
  initial
  begin
    forever #12.5 pclk = ~pclk;
  end
  // Bounded run: a hang counts as a mismatch
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      fails++;
      give_verdict();
    end
  end
  // Random stalls exercise the clock enable inside transfers
  always @(posedge pclk)
  begin
    ce <= ce_jit ? (($urandom % 3) != 0) : 1'b1;
  end

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  // One APB transfer; waits on pready, no fixed latency assumed
  task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d,
                     input logic [3:0] s, output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= s;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      fails++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // Output pins read the latch, input pins the outside level
  function automatic logic [31:0] exp_rd(input logic [7:0] l, d, x);
    return {24'h0, (l & d) | (x & ~d)};
  endfunction : exp_rd
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : give_verdict

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial
  begin
    void'($urandom(86));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, GPAG_DIR_ADDR, 32'h0, 4'hF, rd, err);
    chk(rd, {24'h0, GPAG_DIR_RST});
    chk({24'h0, pad.oe}, 32'h0);
    apb(1'b0, 16'h0000, 32'h0, 4'hF, rd, err);
    chk(rd, GPAG_RD_ZERO);
    chk({31'h0, err}, 32'h1);
    // First two passes: all outputs unclaimed, then all claimed
    // Second half of the passes runs with ce dropping at random
    for (int i = 0; i < 24; i++)
    begin
      ce_jit <= (i >= 12);
      lat = 8'($urandom);
      ext = 8'($urandom);
      dir = (i < 2) ? 8'hFF : 8'($urandom);
      clm = (i == 1) ? 8'hFF : (i == 0) ? 8'h00 : 8'($urandom);
      apb(1'b1, GPAG_DATA_ADDR, {24'h0, lat}, 4'hF, rd, err);
      apb(1'b1, GPAG_DATA_ADDR, {24'h0, ~lat}, 4'hE, rd, err);
      apb(1'b1, GPAG_DIR_ADDR, {24'h0, dir}, 4'hF, rd, err);
      ext_lvl <= ext;
      ana_claim <= clm;
      apb(1'b0, GPAG_DATA_ADDR, 32'h0, 4'hF, rd, err);
      chk(rd, exp_rd(lat, dir, ext));
      chk({31'h0, err}, 32'h0);
      apb(1'b0, GPAG_DIR_ADDR, 32'h0, 4'hF, rd, err);
      chk(rd, {24'h0, dir});
      @(negedge pclk);
      chk({24'h0, pad.out}, {24'h0, lat});
      chk({24'h0, pad.oe}, {24'h0, dir & ~clm});
      chk({24'h0, pad.ana}, {24'h0, clm});
    end
    ce_jit <= 1'b0;
    // Mid-run reset keeps the latch but floats every pin
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    chk({24'h0, pad.out}, {24'h0, lat});
    chk({24'h0, pad.oe}, 32'h0);
    apb(1'b0, GPAG_DIR_ADDR, 32'h0, 4'hF, rd, err);
    chk(rd, 32'h0);
    give_verdict();
  end
endmodule : tb_gpag_port

`default_nettype wire
